// [nfc_host.sv]
/*
 * Host controller for a strobe-driven NAND flash: software programs one
 * command/address/data sequence at a time over APB, the engine drives the pins.
 * Assumes ready_busy_n is pulled up externally and the I/O bus is resolved
 * outside from nand_io_oe.
 */
// The implementer's own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps
module nfc_host
	import nfc_pkg::*;
(
	input wire logic mclk,
	input wire logic reset,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic nand_ce_n,
	output logic nand_cle,
	output logic nand_ale,
	output logic nand_we_n,
	output logic nand_re_n,
	output logic nand_wp_n,
	output logic [7:0] nand_io_out,
	output logic nand_io_oe,
	input wire logic [7:0] nand_io_in,
	input wire logic ready_busy_n
);
	nfc_state_e state_ff, nxt_state;
	logic [31:0] oper_ff;
	logic [15:0] column_ff;
	logic [23:0] row_ff;
	logic [7:0] wdata_ff, rdata_ff, status_ff;
	logic fail_ff, refused_ff, wp_ctl_ff, after_dummy_ff, mp_read_ff;
	logic cache_rd_ff, cache_pg_ff, mp_half_ff, mp_pair_ff;
	logic [PAGE_BITS-1:0] page_ff, mp_page_ff;
	logic [PAGE_BITS-PAGE_IDX_BITS-1:0] pg_block_ff;
	logic [2:0] addr_idx_ff;
	logic [3:0] tim_ff;
	logic half_ff;
	logic [8:0] sync_out;
	logic [7:0] io_sync;
	logic rdy_sync;

	nfc_sync #(.WIDTH(9)) u_sync (
		.mclk(mclk),
		.reset(reset),
		.async_in({ready_busy_n, nand_io_in}),
		.sync_out(sync_out)
	);
	assign io_sync = sync_out[7:0];
	assign rdy_sync = sync_out[8];

	wire logic [7:0] cmd1 = oper_ff[OP_CMD1_LSB +: 8];
	wire logic [7:0] cmd2 = oper_ff[OP_CMD2_LSB +: 8];
	wire logic [2:0] n_addr = oper_ff[OP_ADDR_LSB +: 3];
	wire logic [PAGE_BITS-1:0] row_page = row_ff[PAGE_BITS-1:0];
	wire logic [PAGE_BITS-PAGE_IDX_BITS-1:0] row_block = row_page[PAGE_BITS-1:PAGE_IDX_BITS];
	wire logic wr_access = psel && penable && pwrite;
	wire logic start_req = wr_access && paddr == OFS_OPER && state_ff == ST_IDLE;
	wire logic [7:0] n_cmd1 = pwdata[OP_CMD1_LSB +: 8];
	wire logic [7:0] n_cmd2 = pwdata[OP_CMD2_LSB +: 8];
	wire logic n_use1 = pwdata[OP_USE_CMD1];
	wire logic n_use2 = pwdata[OP_USE_CMD2];
	wire logic n_stat_rst = n_use1 && (n_cmd1 == CMD_STATUS || n_cmd1 == CMD_RESET);
	wire logic strobe_end = tim_ff == 4'h0 && half_ff;
	wire logic low_end = tim_ff == 4'h0 && !half_ff;

	// Order checks made on the request word itself, before anything is driven
	logic refuse;
	always_comb begin
		refuse = 1'b0;
		if (after_dummy_ff && !n_stat_rst && !(n_use1 && n_cmd1 == CMD_PROG_SETUP2))
			refuse = 1'b1;
		if (n_use1 && n_cmd1 == CMD_CACHE_RD && (!cache_rd_ff
				|| page_ff[PAGE_IDX_BITS-1:0] == PAGE_IDX_LAST))
			refuse = 1'b1;
		if (n_use1 && n_cmd1 == CMD_CACHE_LAST && !cache_rd_ff)
			refuse = 1'b1;
		if (n_use2 && n_cmd2 == CMD_PROG_CACHE && cache_pg_ff && row_block != pg_block_ff)
			refuse = 1'b1;
		if (n_use1 && n_cmd1 == CMD_MP_RD_SETUP && mp_half_ff
				&& (row_page[PAGE_IDX_BITS] == mp_page_ff[PAGE_IDX_BITS]
				|| row_page[PAGE_IDX_BITS-1:0] != mp_page_ff[PAGE_IDX_BITS-1:0]))
			refuse = 1'b1;
	end

	// Step through the programmed phases in fixed order
	function automatic nfc_state_e after(input nfc_state_e cur, input logic [31:0] op,
			input logic [2:0] idx);
		nfc_state_e s;
		s = ST_IDLE;
		case (cur)
			ST_PREWAIT: s = op[OP_USE_CMD1] ? ST_CMD1 : ST_ADDR;
			ST_CMD1: s = ST_ADDR;
			ST_ADDR: s = idx == op[OP_ADDR_LSB +: 3] ? ST_WDATA : ST_ADDR;
			ST_WDATA: s = ST_CMD2;
			ST_CMD2: s = ST_ONSET;
			ST_BUSY: s = ST_STCMD;
			ST_STRD: s = ST_RDATA;
			default: s = ST_IDLE;
		endcase
		if (s == ST_ADDR && op[OP_ADDR_LSB +: 3] == 3'h0)
			s = ST_WDATA;
		if (s == ST_WDATA && !op[OP_DATA_WR])
			s = ST_CMD2;
		if (s == ST_CMD2 && !op[OP_USE_CMD2])
			s = ST_ONSET;
		if (s == ST_ONSET && !op[OP_WAIT_RDY])
			s = ST_STCMD;
		if (s == ST_STCMD && !op[OP_AUTO_STAT])
			s = ST_RDATA;
		if (s == ST_RDATA && !op[OP_DATA_RD])
			s = ST_IDLE;
		return s;
	endfunction : after

	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			ST_IDLE: if (start_req && !refuse) nxt_state = ST_PREWAIT;
			ST_PREWAIT: if (rdy_sync || (oper_ff[OP_USE_CMD1] && (cmd1 == CMD_STATUS
					|| cmd1 == CMD_RESET))) nxt_state = after(ST_PREWAIT, oper_ff, 3'h0);
			ST_CMD1, ST_WDATA, ST_CMD2, ST_STRD, ST_RDATA:
				if (strobe_end) nxt_state = after(state_ff, oper_ff, addr_idx_ff);
			ST_ADDR: if (strobe_end) nxt_state = after(ST_ADDR, oper_ff,
					addr_idx_ff + 3'h1 - (n_addr == ADDR_ROW_ONLY ? ADDR_ROW_FIRST : 3'h0));
			ST_ONSET: if (tim_ff == 4'h0) nxt_state = ST_BUSY;
			ST_BUSY: if (rdy_sync) nxt_state = after(ST_BUSY, oper_ff, addr_idx_ff);
			ST_STCMD: if (strobe_end) nxt_state = ST_STRD;
			default: nxt_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (reset)
			state_ff <= ST_IDLE;
		else
			state_ff <= nxt_state;
	end

	// Strobe half-cycle timer; a read strobe stays low longer to cover the synchroniser
	always_ff @(posedge mclk) begin
		if (reset) begin
			tim_ff <= 4'h0;
			half_ff <= 1'b0;
		end else if (nxt_state != state_ff || (state_ff == ST_ADDR && strobe_end)) begin
			// Each address byte is a full strobe of its own
			half_ff <= 1'b0;
			if (nxt_state == ST_ONSET)
				tim_ff <= 4'(BUSY_ONSET_CYC - 1);
			else if (nxt_state == ST_RDATA || nxt_state == ST_STRD)
				tim_ff <= 4'(READ_LOW_CYC - 1);
			else
				tim_ff <= 4'(STROBE_LOW_CYC);
		end else if (low_end) begin
			half_ff <= 1'b1;
			tim_ff <= 4'(STROBE_HIGH_CYC - 1);
		end else if (tim_ff != 4'h0) begin
			tim_ff <= tim_ff - 4'h1;
		end
	end

	// Address cycle index: column bytes first, then page bytes
	always_ff @(posedge mclk) begin
		if (reset)
			addr_idx_ff <= 3'h0;
		else if (nxt_state == ST_ADDR && state_ff != ST_ADDR)
			addr_idx_ff <= n_addr == ADDR_ROW_ONLY ? ADDR_ROW_FIRST : 3'h0;
		else if (state_ff == ST_ADDR && strobe_end)
			addr_idx_ff <= addr_idx_ff + 3'h1;
	end

	logic [7:0] nxt_io;
	always_comb begin
		case (state_ff)
			ST_CMD1: nxt_io = cmd1;
			ST_CMD2: nxt_io = cmd2;
			ST_STCMD: nxt_io = CMD_STATUS;
			ST_WDATA: nxt_io = wdata_ff;
			ST_ADDR: begin
				case (addr_idx_ff)
					3'h0: nxt_io = column_ff[7:0];
					3'h1: nxt_io = column_ff[15:8];
					3'h2: nxt_io = row_ff[7:0];
					3'h3: nxt_io = row_ff[15:8];
					default: nxt_io = row_ff[23:16];
				endcase
			end
			default: nxt_io = 8'h00;
		endcase
	end

	wire logic drive = state_ff == ST_CMD1 || state_ff == ST_CMD2 || state_ff == ST_STCMD
		|| state_ff == ST_ADDR || state_ff == ST_WDATA;
	wire logic reading = state_ff == ST_RDATA || state_ff == ST_STRD;

	always_ff @(posedge mclk) begin
		if (reset) begin
			nand_ce_n <= 1'b1;
			nand_cle <= 1'b0;
			nand_ale <= 1'b0;
			nand_we_n <= 1'b1;
			nand_re_n <= 1'b1;
			nand_io_out <= 8'h00;
			nand_io_oe <= 1'b0;
			nand_wp_n <= 1'b0;
		end else begin
			nand_ce_n <= state_ff == ST_IDLE;
			nand_cle <= state_ff == ST_CMD1 || state_ff == ST_CMD2 || state_ff == ST_STCMD;
			nand_ale <= state_ff == ST_ADDR;
			// First cycle of a write phase keeps the strobe high so latches and data lead its fall
			nand_we_n <= !(drive && !half_ff && tim_ff != 4'(STROBE_LOW_CYC));
			nand_re_n <= !(reading && !half_ff);
			nand_io_out <= nxt_io;
			nand_io_oe <= drive;
			nand_wp_n <= wp_ctl_ff || mp_read_ff;
		end
	end

	// Read data sampled at the end of the low half, after the synchroniser delay
	always_ff @(posedge mclk) begin
		if (reset) begin
			rdata_ff <= 8'h00;
			status_ff <= 8'h00;
		end else if (low_end && state_ff == ST_RDATA) begin
			rdata_ff <= io_sync;
		end else if (low_end && state_ff == ST_STRD) begin
			status_ff <= io_sync;
		end
	end

	// Sequence tracking taken when a request is accepted; mp_read_ff also drops in idle once no pair is open
	wire logic acc = start_req && !refuse;
	always_ff @(posedge mclk) begin
		if (reset) begin
			after_dummy_ff <= 1'b0;
			cache_rd_ff <= 1'b0;
			cache_pg_ff <= 1'b0;
			mp_half_ff <= 1'b0;
			mp_pair_ff <= 1'b0;
			mp_read_ff <= 1'b0;
			page_ff <= '0;
			mp_page_ff <= '0;
			pg_block_ff <= '0;
		end else if (acc) begin
			after_dummy_ff <= n_use2 && n_cmd2 == CMD_PROG_DUMMY ? 1'b1
				: n_stat_rst ? after_dummy_ff : 1'b0;
			if (n_use1 && n_cmd1 == CMD_READ_SETUP && n_use2 && n_cmd2 == CMD_READ_GO) begin
				cache_rd_ff <= 1'b1;
				page_ff <= row_page;
			end else if (n_use1 && n_cmd1 == CMD_CACHE_RD) begin
				page_ff <= page_ff + 17'h1;
			end else if (n_use1 && n_cmd1 == CMD_CACHE_LAST) begin
				cache_rd_ff <= 1'b0;
			end
			if (n_use1 && n_cmd1 == CMD_MP_RD_SETUP) begin
				mp_half_ff <= !mp_half_ff;
				mp_pair_ff <= mp_half_ff;
				mp_page_ff <= row_page;
				mp_read_ff <= 1'b1;
			end
			// Confirm may come as the only command of its own operation
			if (mp_pair_ff && ((n_use1 && n_cmd1 == CMD_READ_GO)
					|| (n_use2 && n_cmd2 == CMD_READ_GO))) begin
				cache_rd_ff <= 1'b1;
				page_ff <= row_page;
				mp_pair_ff <= 1'b0;
			end
			if (n_use2 && n_cmd2 == CMD_PROG_CACHE) begin
				cache_pg_ff <= 1'b1;
				pg_block_ff <= row_block;
			end else if (n_use2 && n_cmd2 == CMD_PROG_GO) begin
				cache_pg_ff <= 1'b0;
			end
		end else if (state_ff == ST_IDLE && mp_read_ff && !mp_half_ff && !mp_pair_ff) begin
			mp_read_ff <= 1'b0;
		end
	end

	// Flags: hardware set beats a software clear in the same cycle
	wire logic clr_wr = wr_access && paddr == OFS_STATUS;
	wire logic fail_set = state_ff == ST_STRD && low_end && io_sync[STAT_FAIL_BIT];
	wire logic refuse_set = start_req && refuse;
	always_ff @(posedge mclk) begin
		if (reset) begin
			fail_ff <= 1'b0;
			refused_ff <= 1'b0;
		end else begin
			fail_ff <= fail_set || (fail_ff && !(clr_wr && pwdata[ST_FAIL]));
			refused_ff <= refuse_set || (refused_ff && !(clr_wr && pwdata[ST_REFUSED]));
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			oper_ff <= 32'h0000_0000;
			column_ff <= 16'h0000;
			row_ff <= 24'h00_0000;
			wdata_ff <= 8'h00;
			wp_ctl_ff <= 1'b0;
		end else if (wr_access) begin
			if (acc)
				oper_ff <= pwdata;
			if (paddr == OFS_COLUMN)
				column_ff <= pwdata[15:0];
			if (paddr == OFS_ROW)
				row_ff <= pwdata[23:0];
			if (paddr == OFS_DATA)
				wdata_ff <= pwdata[7:0];
			if (paddr == OFS_WPCTL)
				wp_ctl_ff <= pwdata[0];
		end
	end

	wire logic mapped = paddr == OFS_OPER || paddr == OFS_COLUMN || paddr == OFS_ROW
		|| paddr == OFS_DATA || paddr == OFS_STATUS || paddr == OFS_WPCTL;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped;

	logic [31:0] nxt_prdata;
	always_comb begin
		nxt_prdata = 32'h0000_0000;
		case (paddr)
			OFS_OPER: nxt_prdata = oper_ff;
			OFS_COLUMN: nxt_prdata = {16'h0000, column_ff};
			OFS_ROW: nxt_prdata = {8'h00, row_ff};
			OFS_DATA: nxt_prdata = {24'h00_0000, rdata_ff};
			OFS_STATUS: begin
				nxt_prdata[ST_ACTIVE] = state_ff != ST_IDLE;
				nxt_prdata[ST_FAIL] = fail_ff;
				nxt_prdata[ST_REFUSED] = refused_ff;
				nxt_prdata[ST_READY] = rdy_sync;
				nxt_prdata[ST_AFTER_DUMMY] = after_dummy_ff;
				nxt_prdata[ST_BYTE_LSB +: 8] = status_ff;
			end
			OFS_WPCTL: nxt_prdata = {31'h0000_0000, wp_ctl_ff};
			default: nxt_prdata = 32'h0000_0000;
		endcase
	end

	// Read data registered at setup so it is stable through the access phase
	always_ff @(posedge mclk) begin
		if (reset)
			prdata <= 32'h0000_0000;
		else if (psel && !penable)
			prdata <= nxt_prdata;
	end
endmodule : nfc_host

// [nfc_pkg.sv]
/*
 * Shared constants of the NAND sequencing host: register map, control field
 * positions, device command codes, address layout and pin timing.
 * Assumes a 100 MHz mclk; all cycle counts derive from CLK_PERIOD_NS.
 */
package nfc_pkg;
	localparam int CLK_PERIOD_NS = 10;

	// Register byte offsets
	localparam logic [7:0] OFS_OPER = 8'h00;
	localparam logic [7:0] OFS_COLUMN = 8'h04;
	localparam logic [7:0] OFS_ROW = 8'h08;
	localparam logic [7:0] OFS_DATA = 8'h0C;
	localparam logic [7:0] OFS_STATUS = 8'h10;
	localparam logic [7:0] OFS_WPCTL = 8'h14;

	// Operation register fields
	localparam int OP_CMD1_LSB = 0;
	localparam int OP_CMD2_LSB = 8;
	localparam int OP_USE_CMD1 = 16;
	localparam int OP_USE_CMD2 = 17;
	localparam int OP_ADDR_LSB = 18;
	localparam int OP_WAIT_RDY = 21;
	localparam int OP_AUTO_STAT = 22;
	localparam int OP_DATA_WR = 23;
	localparam int OP_DATA_RD = 24;

	// Status register fields
	localparam int ST_ACTIVE = 0;
	localparam int ST_FAIL = 1;
	localparam int ST_REFUSED = 2;
	localparam int ST_READY = 3;
	localparam int ST_AFTER_DUMMY = 4;
	localparam int ST_BYTE_LSB = 8;

	// Device command codes
	localparam logic [7:0] CMD_READ_SETUP = 8'h00;
	localparam logic [7:0] CMD_READ_GO = 8'h30;
	localparam logic [7:0] CMD_CACHE_RD = 8'h31;
	localparam logic [7:0] CMD_CACHE_LAST = 8'h3F;
	localparam logic [7:0] CMD_MP_RD_SETUP = 8'h60;
	localparam logic [7:0] CMD_PROG_SETUP = 8'h80;
	localparam logic [7:0] CMD_PROG_SETUP2 = 8'h81;
	localparam logic [7:0] CMD_COL_CHANGE = 8'h85;
	localparam logic [7:0] CMD_PROG_GO = 8'h10;
	localparam logic [7:0] CMD_PROG_DUMMY = 8'h11;
	localparam logic [7:0] CMD_PROG_CACHE = 8'h15;
	localparam logic [7:0] CMD_STATUS = 8'h70;
	localparam logic [7:0] CMD_RESET = 8'hFF;

	// Address layout: two column cycles, three page cycles
	localparam logic [2:0] ADDR_FULL = 3'h5;
	localparam logic [2:0] ADDR_ROW_ONLY = 3'h3;
	localparam logic [2:0] ADDR_ROW_FIRST = 3'h2;
	localparam int PAGE_BITS = 17;
	localparam int PAGE_IDX_BITS = 6;
	localparam logic [5:0] PAGE_IDX_LAST = 6'h3F;
	localparam int STAT_FAIL_BIT = 0;

	// Pin timing
	localparam int STROBE_LOW_NS = 25;
	localparam int STROBE_HIGH_NS = 15;
	localparam int BUSY_ONSET_NS = 100;
	localparam int SYNC_STAGES = 2;
	localparam int STROBE_LOW_CYC = (STROBE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int STROBE_HIGH_CYC = (STROBE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int BUSY_ONSET_CYC = (BUSY_ONSET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int READ_LOW_CYC = STROBE_LOW_CYC + SYNC_STAGES;

	typedef enum logic [10:0] {
		ST_IDLE = 11'b00000000001,
		ST_PREWAIT = 11'b00000000010,
		ST_CMD1 = 11'b00000000100,
		ST_ADDR = 11'b00000001000,
		ST_WDATA = 11'b00000010000,
		ST_CMD2 = 11'b00000100000,
		ST_ONSET = 11'b00001000000,
		ST_BUSY = 11'b00010000000,
		ST_STCMD = 11'b00100000000,
		ST_STRD = 11'b01000000000,
		ST_RDATA = 11'b10000000000
	} nfc_state_e;
endpackage : nfc_pkg

// [nfc_sync.sv]
/*
 * Two-stage synchroniser, one stage pair per bit.
 * Assumes inputs are asynchronous pins; only the second stage is read outside.
 */
`timescale 1ns/10ps
module nfc_sync #(
	parameter int WIDTH = 1
) (
	input wire logic mclk,
	input wire logic reset,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_ff;

	for (genvar i = 0; i < WIDTH; i++) begin : g_bit
		always_ff @(posedge mclk) begin
			if (reset) begin
				meta_ff[i] <= 1'b0;
				sync_out[i] <= 1'b0;
			end else begin
				meta_ff[i] <= async_in[i];
				sync_out[i] <= meta_ff[i];
			end
		end
	end
endmodule : nfc_sync

// [nfc_host_properties.sv]
/* Checker on the nfc_host ports: strobe shapes, pin phases, APB error answer.
 Assumes it is bound to nfc_host; one clock, synchronous reset. */
`timescale 1ns/10ps
module nfc_host_properties
	import nfc_pkg::*;
(
	input wire logic mclk,
	input wire logic reset,
	input wire logic psel,
	input wire logic penable,
	input wire logic [7:0] paddr,
	input wire logic pslverr,
	input wire logic nand_ce_n,
	input wire logic nand_cle,
	input wire logic nand_ale,
	input wire logic nand_we_n,
	input wire logic nand_re_n,
	input wire logic nand_io_oe,
	input wire logic [7:0] nand_io_out
);
	default clocking @(posedge mclk); endclocking
	default disable iff (reset);
	logic mapped;
	assign mapped = paddr[1:0] == 2'h0 && paddr <= OFS_WPCTL;
	property p_err; pslverr == (psel && penable && !mapped); endproperty
	a_err: assert property (p_err) else $error("slave error mismatch");
	property p_we_len; $fell(nand_we_n) |-> !nand_we_n [*3] ##1 nand_we_n; endproperty
	a_we_len: assert property (p_we_len) else $error("write strobe width");
	property p_re_len; $fell(nand_re_n) |-> !nand_re_n [*5] ##1 nand_re_n; endproperty
	a_re_len: assert property (p_re_len) else $error("read strobe width");
	property p_we_gap; $rose(nand_we_n) |-> nand_we_n [*2]; endproperty
	a_we_gap: assert property (p_we_gap) else $error("write strobe gap");
	property p_hold; !nand_we_n |-> $stable({nand_cle, nand_ale, nand_io_out}) && nand_io_oe;
	endproperty
	a_hold: assert property (p_hold) else $error("phase moved under strobe");
	property p_rd; !nand_re_n |-> nand_we_n && !nand_cle && !nand_ale && !nand_io_oe; endproperty
	a_rd: assert property (p_rd) else $error("read cycle not clean");
	property p_sel; !(nand_we_n && nand_re_n) |-> !nand_ce_n; endproperty
	a_sel: assert property (p_sel) else $error("strobe without chip enable");
	property p_lat; !(nand_cle && nand_ale); endproperty
	a_lat: assert property (p_lat) else $error("both latch enables high");
endmodule : nfc_host_properties

bind nfc_host nfc_host_properties i_chk (.mclk, .reset, .psel, .penable, .paddr, .pslverr,
	.nand_ce_n, .nand_cle, .nand_ale, .nand_we_n, .nand_re_n, .nand_io_oe, .nand_io_out);

// [nfc_flash_model.sv]
/* Behavioural flash device answering the host's strobes.
 Assumes one host; busy time is one fixed figure for every array action. */
`timescale 1ns/10ps
module nfc_flash_model #(
	parameter int T_BUSY_NS = 600
) (
	input wire logic ce_n,
	input wire logic cle,
	input wire logic ale,
	input wire logic we_n,
	input wire logic re_n,
	input wire logic wp_n,
	input wire logic fail_inj,
	input wire logic [7:0] din,
	output logic [7:0] dout,
	output logic rb_n
);
	logic [7:0] pbuf [0:255];
	logic [11:0] col, last_col;
	logic [16:0] page;
	logic [2:0] acnt;
	logic stat_mode, cur_fail, prev_fail;
	initial begin
		dout = 8'h00;
		rb_n = 1'b1;
		stat_mode = 1'b0;
		cur_fail = 1'b0;
		prev_fail = 1'b0;
	end
	always @(posedge we_n) begin
		if (!ce_n && cle) begin
			stat_mode = din == 8'h70;
			acnt = (din == 8'h60) ? 3'h2 : 3'h0;
			if (din == 8'h31 || din == 8'h3F) begin
				page = page + 17'h1;
				col = 12'h0;
			end
			if (din == 8'h10 || din == 8'h15) begin
				prev_fail = cur_fail;
				cur_fail = fail_inj;
			end
			// Release is scheduled, so a status read during busy sees the low level
			if (din inside {8'h30, 8'h31, 8'h3F, 8'h10, 8'h15, 8'h11}) begin
				rb_n = 1'b0;
				rb_n <= #(T_BUSY_NS) 1'b1;
			end
		end else if (!ce_n && ale) begin
			case (acnt)
				3'h0: col[7:0] = din;
				3'h1: col[11:8] = din[3:0];
				3'h2: page[7:0] = din;
				3'h3: page[15:8] = din;
				default: page[16] = din[0];
			endcase
			last_col = col;
			acnt = acnt + 3'h1;
		end else if (!ce_n) begin
			pbuf[col[7:0]] = din;
			col = col + 12'h1;
		end
	end
	always @(negedge re_n) begin
		if (!ce_n && stat_mode)
			dout = {wp_n, rb_n, rb_n, 3'h0, prev_fail, cur_fail};
		else if (!ce_n) begin
			dout = col[7:0] ^ page[7:0] ^ 8'h5A;
			col = col + 12'h1;
		end
	end
	// Released data lines flip so a stale byte is never mistaken for a fresh one
	always @(posedge re_n) dout = ~dout;
endmodule : nfc_flash_model

// [nfc_host_tb.sv]
/* Self-checking bench of nfc_host driving the flash model over APB.
 Assumes the checker binds itself; expected bytes follow the model's pattern. */
`timescale 1ns/10ps
module nfc_host_tb
	import nfc_pkg::*;
;
	logic mclk, reset, psel, penable, pwrite, pready, pslverr, serr, fail_inj;
	logic [7:0] paddr, nand_io_out, nand_io_in;
	logic [31:0] pwdata, prdata, rdat;
	logic nand_ce_n, nand_cle, nand_ale, nand_we_n, nand_re_n, nand_wp_n, nand_io_oe, ready_busy_n;
	int err_count = 0;
	int checked = 0;
	nfc_host i_dut (.mclk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .nand_ce_n, .nand_cle, .nand_ale, .nand_we_n, .nand_re_n, .nand_wp_n,
		.nand_io_out, .nand_io_oe, .nand_io_in, .ready_busy_n);
	nfc_flash_model i_flash (.ce_n(nand_ce_n), .cle(nand_cle), .ale(nand_ale), .we_n(nand_we_n),
		.re_n(nand_re_n), .wp_n(nand_wp_n), .fail_inj(fail_inj), .din(nand_io_out),
		.dout(nand_io_in), .rb_n(ready_busy_n));
	function automatic logic [7:0] pat(input logic [11:0] c, input logic [16:0] p);
		return c[7:0] ^ p[7:0] ^ 8'h5A;
	endfunction : pat
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic stop_test();
		$display("checks %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : stop_test
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do @(posedge mclk); while (pready !== 1'b1);
		rdat = prdata;
		serr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic op(input logic [31:0] w);
		apb(1'b1, OFS_OPER, w);
		do apb(1'b0, OFS_STATUS, 32'h0); while (rdat[ST_ACTIVE] !== 1'b0);
	endtask : op
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	initial begin
		#300000;
		err_count++;
		stop_test();
	end
	initial begin
		{reset, psel, penable, pwrite, fail_inj, paddr, pwdata} = {5'h10, 8'h00, 32'h0};
		repeat (10) @(posedge mclk);
		reset <= 1'b0;
		// Let the ready synchroniser fill before the first status read
		repeat (2) @(posedge mclk);
		apb(1'b0, OFS_STATUS, 32'h0);
		chk("st_rst", rdat[3:0], 4'h8);
		chk("wp_rst", nand_wp_n, 0);
		apb(1'b1, 8'h18, 32'h1);
		chk("unm_err", serr, 1);
		apb(1'b0, 8'h18, 32'h0);
		chk("unm_rd", rdat, 0);
		op(32'h0001_0031);
		chk("ref31", rdat[ST_REFUSED], 1);
		apb(1'b1, OFS_STATUS, 32'h6);
		op(32'h0001_003F);
		chk("ref3f", rdat[ST_REFUSED], 1);
		apb(1'b1, OFS_STATUS, 32'h6);
		op(32'h0101_0070);
		chk("clr", rdat[ST_REFUSED], 0);
		apb(1'b0, OFS_DATA, 32'h0);
		chk("stat", rdat[7:0], 8'h60);
		apb(1'b1, OFS_WPCTL, 32'h1);
		apb(1'b1, OFS_COLUMN, 32'h123);
		apb(1'b1, OFS_ROW, 32'h10041);
		op(32'h0137_3000);
		apb(1'b0, OFS_DATA, 32'h0);
		chk("rd0", rdat[7:0], pat(12'h123, 17'h10041));
		chk("col", i_flash.last_col, 32'h123);
		chk("page", i_flash.page, 32'h10041);
		op(32'h0100_0000);
		apb(1'b0, OFS_DATA, 32'h0);
		chk("rd1", rdat[7:0], pat(12'h124, 17'h10041));
		op(32'h0121_0031);
		apb(1'b0, OFS_DATA, 32'h0);
		chk("rd31", rdat[7:0], pat(12'h0, 17'h10042));
		op(32'h0121_003F);
		apb(1'b0, OFS_DATA, 32'h0);
		chk("rd3f", rdat[7:0], pat(12'h0, 17'h10043));
		apb(1'b1, OFS_COLUMN, 32'h10);
		apb(1'b1, OFS_ROW, 32'h80);
		apb(1'b1, OFS_DATA, 32'hA5);
		op(32'h0095_0080);
		apb(1'b1, OFS_COLUMN, 32'h20);
		apb(1'b1, OFS_DATA, 32'h3C);
		op(32'h0089_0085);
		op(32'h0061_0010);
		chk("pb10", i_flash.pbuf[16], 8'hA5);
		chk("pb20", i_flash.pbuf[32], 8'h3C);
		chk("wp_on", nand_wp_n, 1);
		chk("pst", {rdat[15:8], rdat[1]}, 9'h1C0);
		op(32'h0037_1580);
		apb(1'b1, OFS_ROW, 32'hC0);
		op(32'h0037_1580);
		chk("ref15", rdat[ST_REFUSED], 1);
		apb(1'b1, OFS_STATUS, 32'h6);
		apb(1'b1, OFS_ROW, 32'h80);
		fail_inj <= 1'b1;
		op(32'h0077_1080);
		chk("cfail", {rdat[15:8], rdat[1]}, 9'h1C3);
		fail_inj <= 1'b0;
		apb(1'b1, OFS_STATUS, 32'h6);
		op(32'h0037_1180);
		chk("dummy", rdat[ST_AFTER_DUMMY], 1);
		op(32'h0015_0080);
		chk("ref11", rdat[ST_REFUSED], 1);
		apb(1'b1, OFS_STATUS, 32'h6);
		op(32'h0077_1081);
		chk("mp", {rdat[4], rdat[2:1]}, 0);
		apb(1'b1, OFS_WPCTL, 32'h0);
		apb(1'b1, OFS_ROW, 32'hC5);
		op(32'h000D_0060);
		chk("mwp", nand_wp_n, 1);
		apb(1'b1, OFS_ROW, 32'h05);
		op(32'h000D_0060);
		chk("mwp2", nand_wp_n, 1);
		op(32'h0021_0030);
		chk("mrd", rdat[ST_REFUSED], 0);
		op(32'h0121_0031);
		apb(1'b0, OFS_DATA, 32'h0);
		chk("mrd31", rdat[7:0], pat(12'h0, 17'h6));
		apb(1'b1, OFS_ROW, 32'h85);
		op(32'h000D_0060);
		apb(1'b1, OFS_ROW, 32'h105);
		op(32'h000D_0060);
		chk("mdist", rdat[ST_REFUSED], 1);
		apb(1'b1, OFS_STATUS, 32'h6);
		apb(1'b1, OFS_ROW, 32'h46);
		op(32'h000D_0060);
		chk("mpage", rdat[ST_REFUSED], 1);
		stop_test();
	end
endmodule : nfc_host_tb
